// ---- src/energy_accum_pkg.sv ----
package energy_accum_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_LINE_ACTIVE_ENERGY = 8'h04;
  localparam logic [7:0] ADDR_HALF_CYCLE_COUNT = 8'h1c;
  localparam logic [7:0] ADDR_MODE = 8'h20;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
  localparam logic [7:0] ADDR_APPARENT_GAIN = 8'h2c;
  localparam logic [7:0] ADDR_APPARENT_ENERGY = 8'h30;
  localparam logic [7:0] ADDR_LINE_REACTIVE_ENERGY = 8'h34;

  // ==========================================================
  // Field positions
  localparam int MODE_CYC_BIT = 7;
  localparam int MODE_POS_ONLY_BIT = 15;
  localparam int ST_CYCLE_DONE_BIT = 2;
  localparam int ST_WENT_POS_BIT = 3;
  localparam int ST_WENT_NEG_BIT = 4;

  // ==========================================================
  // Widths and reset values
  localparam int DATA_W = 32;
  localparam int ENERGY_W = 24;
  localparam int POWER_W = 24;
  localparam int APP_ACC_W = 52;
  localparam int GAIN_W = 12;
  localparam int HALF_W = 16;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] HALF_CYCLE_RESET = 16'hffff;

  // ==========================================================
  // Timing: one accumulation every four master clock periods
  localparam int ACC_PERIOD = 4;
  localparam logic [1:0] ACC_DIV_LAST = 2'(ACC_PERIOD - 1);

  // No-load threshold, 0.001 percent of full scale (2^23 / 100000)
  localparam logic [23:0] NO_LOAD_THRESHOLD = 24'h000054;

  // Sample stream from the signal path
  typedef struct packed {
    logic signed [23:0] active;
    logic signed [23:0] reactive;
    logic [23:0] i_rms;
    logic [23:0] v_rms;
  } samples_s;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// ---- src/energy_accum.sv ----
`timescale 1ns/1ps
// Functional notes
// - Mode register bit 7 set selects line-cycle accumulation
// - Line mode sums active power between voltage zero crossings
// - Half-cycle count per period comes from 16-bit register
// - Period end sets line-cycle-done flag, status bit 2
// - Enabled line-cycle-done flag pulls interrupt request low
// - New period starts right after each one while mode set
// - Mode bit 15 accumulates positive active power only, off at reset
// - Power sign change sets went-positive or went-negative flag, interrupt
// - No active energy accumulation while active power magnitude below no-load threshold
// - Reactive power is plus-ninety shifted current times voltage, filtered
// - Reactive power accumulated over same half cycles with done flag
// - Apparent power is current RMS times voltage RMS, no offset
// - Apparent power scaled by one plus signed gain over 4096
// - 52-bit apparent accumulator, upper 24 bits readable
// - Accumulators add one sample every four clock periods
// - Apparent power added as signed two's complement
// - Apparent energy wraps from positive full scale to negative
module energy_accum (
  input wire logic clk,
  input wire logic rstn,
  input wire energy_accum_pkg::reg_req_s req,
  output logic [31:0] rdata,
  input wire energy_accum_pkg::samples_s smp,
  input wire logic zero_cross,
  output logic irq_n
);
  import energy_accum_pkg::*;

  // ==========================================================
  // Registers
  logic [15:0] mode_q;
  logic [15:0] half_cycle_count_q;
  logic [4:0] irq_enable_q;
  logic [4:0] irq_status_q;
  logic [11:0] apparent_gain_q;
  logic [23:0] line_active_energy_q;
  logic [23:0] line_reactive_energy_q;
  logic signed [47:0] line_active_acc_q;
  logic signed [47:0] line_reactive_acc_q;
  logic signed [51:0] app_acc_q;
  logic [1:0] div_q;
  logic acc_tick;
  logic zc_meta_q, zc_sync_q, zc_prev_q;
  logic [1:0] zc_fill_q;
  logic signed [51:0] app_sum;
  logic zc_edge;
  logic [15:0] half_left_q;
  logic cycle_done;
  logic sign_q;
  logic went_pos, went_neg;
  logic active_loaded;
  logic signed [47:0] active_ext;
  logic signed [47:0] reactive_ext;
  logic [47:0] app_raw;
  logic signed [61:0] app_scaled;
  logic signed [51:0] app_add;
  logic [23:0] act_mag;
  logic cyc_mode, pos_only;

  assign cyc_mode = mode_q[MODE_CYC_BIT];
  assign pos_only = mode_q[MODE_POS_ONLY_BIT];

  // ==========================================================
  // Accumulation tick every four master clock periods
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 2'h0;
    end else if (div_q == ACC_DIV_LAST) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign acc_tick = (div_q == ACC_DIV_LAST);

  // ==========================================================
  // Zero-crossing pin synchroniser and edge detect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      zc_meta_q <= 1'b0;
      zc_sync_q <= 1'b0;
      zc_prev_q <= 1'b0;
    end else begin
      zc_meta_q <= zero_cross;
      zc_sync_q <= zc_meta_q;
      zc_prev_q <= zc_sync_q;
    end
  end
  // Edge detect stays quiet until the synchroniser holds the real pin level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      zc_fill_q <= 2'h0;
    end else if (!(&zc_fill_q)) begin
      zc_fill_q <= zc_fill_q + 2'h1;
    end
  end
  // Both edges are voltage zero crossings, one half cycle each
  assign zc_edge = (&zc_fill_q) && (zc_sync_q ^ zc_prev_q);

  // ==========================================================
  // Half-cycle counter, reloads at each period end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      half_left_q <= HALF_CYCLE_RESET;
    end else if (!cyc_mode) begin
      half_left_q <= half_cycle_count_q;
    end else if (zc_edge) begin
      if (half_left_q <= 16'h0001) begin
        half_left_q <= half_cycle_count_q;
      end else begin
        half_left_q <= half_left_q - 16'h0001;
      end
    end
  end
  assign cycle_done = cyc_mode && zc_edge && (half_left_q <= 16'h0001);

  // ==========================================================
  // Active power path: no-load gate and positive-only filter
  assign act_mag = smp.active[23] ? 24'(-smp.active) : smp.active;
  assign active_loaded = (act_mag >= NO_LOAD_THRESHOLD)
                         && !(pos_only && smp.active[23]);
  assign active_ext = active_loaded ? 48'(smp.active) : 48'sh0;
  // Reactive input is the filtered product of shifted current and voltage
  assign reactive_ext = 48'(smp.reactive);

  // Line energy accumulators; period result latched at period end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_active_acc_q <= 48'sh0;
      line_reactive_acc_q <= 48'sh0;
      line_active_energy_q <= 24'h0;
      line_reactive_energy_q <= 24'h0;
    end else if (cycle_done) begin
      // First period after enabling starts mid-cycle, so software drops it
      line_active_energy_q <= line_active_acc_q[47:24];
      line_reactive_energy_q <= line_reactive_acc_q[47:24];
      line_active_acc_q <= 48'sh0;
      line_reactive_acc_q <= 48'sh0;
    end else if (cyc_mode && acc_tick) begin
      line_active_acc_q <= line_active_acc_q + active_ext;
      line_reactive_acc_q <= line_reactive_acc_q + reactive_ext;
    end else if (!cyc_mode) begin
      line_active_acc_q <= 48'sh0;
      line_reactive_acc_q <= 48'sh0;
    end
  end

  // ==========================================================
  // Apparent power: RMS product scaled by gain, signed accumulation
  assign app_raw = smp.i_rms * smp.v_rms;
  // Factor held in 14 bits so that one plus the largest gain cannot wrap negative
  assign app_scaled = 62'($signed({1'b0, app_raw[47:24]})) *
                      62'($signed({{2{apparent_gain_q[11]}}, apparent_gain_q} + 14'h1000));
  assign app_add = 52'(app_scaled >>> GAIN_W);
  // Plain two's complement sum, wraps from positive full scale to negative
  assign app_sum = app_acc_q + app_add;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      app_acc_q <= 52'sh0;
    end else if (acc_tick) begin
      app_acc_q <= app_sum;
    end
  end

  // ==========================================================
  // Power sign tracking
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sign_q <= 1'b0;
    end else if (acc_tick && act_mag >= NO_LOAD_THRESHOLD) begin
      sign_q <= smp.active[23];
    end
  end
  assign went_pos = acc_tick && (act_mag >= NO_LOAD_THRESHOLD) && sign_q && !smp.active[23];
  assign went_neg = acc_tick && (act_mag >= NO_LOAD_THRESHOLD) && !sign_q && smp.active[23];

  // ==========================================================
  // Software registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_RESET;
      half_cycle_count_q <= HALF_CYCLE_RESET;
      irq_enable_q <= 5'h00;
      apparent_gain_q <= 12'h000;
    end else if (req.wr) begin
      unique case (req.addr)
        ADDR_MODE: mode_q <= req.wdata[15:0];
        ADDR_HALF_CYCLE_COUNT: half_cycle_count_q <= req.wdata[15:0];
        ADDR_IRQ_ENABLE: irq_enable_q <= req.wdata[4:0];
        ADDR_APPARENT_GAIN: apparent_gain_q <= req.wdata[11:0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear, hardware set wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status_q <= 5'h00;
    end else begin
      for (int b = 0; b < 5; b++) begin
        if ((b == ST_CYCLE_DONE_BIT && cycle_done) ||
            (b == ST_WENT_POS_BIT && went_pos) ||
            (b == ST_WENT_NEG_BIT && went_neg)) begin
          irq_status_q[b] <= 1'b1;
        end else if (req.wr && req.addr == ADDR_IRQ_STATUS && req.wdata[b]) begin
          irq_status_q[b] <= 1'b0;
        end
      end
    end
  end

  // Interrupt request, active low, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(irq_status_q & irq_enable_q);
    end
  end

  // Read data, one cycle after read strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0;
    end else if (req.rd) begin
      unique case (req.addr)
        ADDR_LINE_ACTIVE_ENERGY: rdata <= {8'h00, line_active_energy_q};
        ADDR_HALF_CYCLE_COUNT: rdata <= {16'h0000, half_cycle_count_q};
        ADDR_MODE: rdata <= {16'h0000, mode_q};
        ADDR_IRQ_ENABLE: rdata <= {27'h0, irq_enable_q};
        ADDR_IRQ_STATUS: rdata <= {27'h0, irq_status_q};
        ADDR_APPARENT_GAIN: rdata <= {20'h0, apparent_gain_q};
        ADDR_APPARENT_ENERGY: rdata <= {8'h00, app_acc_q[51:28]};
        ADDR_LINE_REACTIVE_ENERGY: rdata <= {8'h00, line_reactive_energy_q};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  // ==========================================================
  // Assertions
  // Tick divider
  a_tick_spacing: assert property (@(posedge clk) disable iff (!rstn)
    acc_tick |=> !acc_tick [*3] ##1 acc_tick)
    else $error("tick spacing wrong");
  a_app_hold: assert property (@(posedge clk) disable iff (!rstn)
    !acc_tick |=> $stable(app_acc_q))
    else $error("apparent changed off tick");

  // ==========================================================
  // Half-cycle counting and period end
  a_mode_off_idle: assert property (@(posedge clk) disable iff (!rstn)
    !cyc_mode |=> line_active_acc_q == 48'sh0)
    else $error("line sum kept without mode");
  a_reload_count: assert property (@(posedge clk) disable iff (!rstn)
    cycle_done |=> half_left_q == $past(half_cycle_count_q))
    else $error("count not reloaded");
  a_count_down: assert property (@(posedge clk) disable iff (!rstn)
    cyc_mode && zc_edge && !cycle_done && !(req.wr && req.addr == ADDR_MODE)
    |=> half_left_q == $past(half_left_q) - 16'h0001) else $error("half count wrong");
  a_count_load: assert property (@(posedge clk) disable iff (!rstn)
    !cyc_mode |=> half_left_q == $past(half_cycle_count_q))
    else $error("count not loaded");
  a_zc_prime: assert property (@(posedge clk) disable iff (!rstn)
    !(&zc_fill_q) |-> !zc_edge)
    else $error("edge before synchroniser filled");
  a_count_write: assert property (@(posedge clk) disable iff (!rstn)
    req.wr && req.addr == ADDR_HALF_CYCLE_COUNT |=> half_cycle_count_q == $past(req.wdata[15:0]))
    else $error("count write lost");
  a_mode_write: assert property (@(posedge clk) disable iff (!rstn)
    req.wr && req.addr == ADDR_MODE |=> mode_q == $past(req.wdata[15:0]))
    else $error("mode write lost");

  // ==========================================================
  // Line energy accumulation
  a_line_latch: assert property (@(posedge clk) disable iff (!rstn)
    cycle_done |=> line_active_energy_q == $past(line_active_acc_q[47:24]) && line_active_acc_q == 48'sh0)
    else $error("line energy not latched");
  a_line_energy_hold: assert property (@(posedge clk) disable iff (!rstn)
    !cycle_done |=> $stable(line_active_energy_q))
    else $error("line energy moved mid period");
  a_line_hold: assert property (@(posedge clk) disable iff (!rstn)
    cyc_mode && !cycle_done && !acc_tick |=> $stable(line_active_acc_q))
    else $error("line sum moved off tick");
  a_reactive_latch: assert property (@(posedge clk) disable iff (!rstn)
    cycle_done |=> line_reactive_energy_q == $past(line_reactive_acc_q[47:24]))
    else $error("reactive energy not latched");
  a_reactive_add: assert property (@(posedge clk) disable iff (!rstn)
    cyc_mode && acc_tick && !cycle_done |=> line_reactive_acc_q == $past(line_reactive_acc_q) + $past(reactive_ext))
    else $error("reactive add wrong");
  a_pos_only: assert property (@(posedge clk) disable iff (!rstn)
    pos_only && smp.active[23] |-> active_ext == 48'sh0)
    else $error("negative accumulated");
  a_no_load: assert property (@(posedge clk) disable iff (!rstn)
    act_mag < NO_LOAD_THRESHOLD |-> active_ext == 48'sh0)
    else $error("creep accumulated");

  // ==========================================================
  // Apparent energy
  a_app_add: assert property (@(posedge clk) disable iff (!rstn)
    acc_tick |=> app_acc_q == $past(app_acc_q) + $past(app_add))
    else $error("apparent add wrong");
  a_gain_unity: assert property (@(posedge clk) disable iff (!rstn)
    apparent_gain_q == 12'h000 |-> app_add == 52'(app_raw[47:24]))
    else $error("unity gain scaled");
  a_app_wrap: assert property (@(posedge clk) disable iff (!rstn)
    acc_tick && !app_acc_q[51] && !app_add[51] && app_sum[51] |=> app_acc_q[51])
    else $error("apparent did not wrap");
  a_app_read: assert property (@(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ADDR_APPARENT_ENERGY |=> rdata == {8'h00, $past(app_acc_q[51:28])})
    else $error("apparent read wrong");

  // ==========================================================
  // Status flags and interrupt request
  a_done_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
    cycle_done |=> irq_status_q[ST_CYCLE_DONE_BIT])
    else $error("done flag not set");
  a_status_sticky: assert property (@(posedge clk) disable iff (!rstn)
    irq_status_q[ST_CYCLE_DONE_BIT] && !(req.wr && req.addr == ADDR_IRQ_STATUS && req.wdata[ST_CYCLE_DONE_BIT])
    |=> irq_status_q[ST_CYCLE_DONE_BIT]) else $error("done flag dropped");
  a_status_clear: assert property (@(posedge clk) disable iff (!rstn)
    req.wr && req.addr == ADDR_IRQ_STATUS && req.wdata[ST_CYCLE_DONE_BIT] && !cycle_done
    |=> !irq_status_q[ST_CYCLE_DONE_BIT]) else $error("done flag not cleared");
  a_done_irq: assert property (@(posedge clk) disable iff (!rstn)
    cycle_done && irq_enable_q[ST_CYCLE_DONE_BIT] |=> ##1 !irq_n)
    else $error("irq not low");
  a_irq_idle: assert property (@(posedge clk) disable iff (!rstn)
    !(|(irq_status_q & irq_enable_q)) |=> irq_n)
    else $error("irq low without cause");
  a_sign_flags: assert property (@(posedge clk) disable iff (!rstn)
    went_neg |=> irq_status_q[ST_WENT_NEG_BIT])
    else $error("neg flag not set");
  a_went_pos_flag: assert property (@(posedge clk) disable iff (!rstn)
    went_pos |=> irq_status_q[ST_WENT_POS_BIT])
    else $error("pos flag not set");
  a_sign_irq: assert property (@(posedge clk) disable iff (!rstn)
    went_pos && irq_enable_q[ST_WENT_POS_BIT] |=> ##1 !irq_n)
    else $error("sign irq not low");
  a_no_load_sign: assert property (@(posedge clk) disable iff (!rstn)
    act_mag < NO_LOAD_THRESHOLD |=> sign_q == $past(sign_q))
    else $error("sign moved below threshold");

  // Main scenarios
  c_cycle_done: cover property (@(posedge clk) disable iff (!rstn) cycle_done);
  c_went_pos: cover property (@(posedge clk) disable iff (!rstn) went_pos);
  c_went_neg: cover property (@(posedge clk) disable iff (!rstn) went_neg);
  c_pos_only_drop: cover property (@(posedge clk) disable iff (!rstn) acc_tick && pos_only && smp.active[23]);
  c_irq_low: cover property (@(posedge clk) disable iff (!rstn) !irq_n);

endmodule // energy_accum

// ---- bench/energy_accum_tb.sv ----
`timescale 1ns/1ps
module energy_accum_tb;
  import energy_accum_pkg::*;
  // ==========================================================
  // Clock, reset and design hookup
  typedef struct {logic [7:0] a; logic wr; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  reg_req_s req = '0;
  samples_s smp = '0;
  logic zero_cross = 1'b0;
  logic [31:0] rdata;
  logic irq_n;
  logic [31:0] got, e0;
  logic [23:0] dlt;
  int n_mismatch = 0;
  int num_checks = 0;
  row_t rows[14] = '{'{8'h20, 1'b0, 32'h0, 32'h0}, '{8'h1c, 1'b0, 32'h0, 32'hffff},
    '{8'h24, 1'b0, 32'h0, 32'h0}, '{8'h28, 1'b0, 32'h0, 32'h0}, '{8'h2c, 1'b0, 32'h0, 32'h0},
    '{8'h04, 1'b0, 32'h0, 32'h0}, '{8'h30, 1'b0, 32'h0, 32'h0}, '{8'h34, 1'b0, 32'h0, 32'h0},
    '{8'h1c, 1'b1, 32'h12345678, 32'h5678}, '{8'h2c, 1'b1, 32'hffffffff, 32'hfff},
    '{8'h24, 1'b1, 32'h1f, 32'h1f}, '{8'h04, 1'b1, 32'hffffff, 32'h0},
    '{8'h40, 1'b1, 32'hffffffff, 32'h0}, '{8'h24, 1'b1, 32'h0, 32'h0}};
  // Free-running 200 MHz clock
  always #2.5 clk = ~clk;
  energy_accum dut_u (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .smp(smp),
    .zero_cross(zero_cross), .irq_n(irq_n));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(a, d);
    check(d, exp);
  endtask
  // Half cycles of 40 clocks, then time for the synchroniser
  task automatic zc(input int n);
    repeat (n) begin
      repeat (40) @(posedge clk);
      zero_cross <= ~zero_cross;
    end
    repeat (10) @(posedge clk);
  endtask
  task automatic wait_irq;
    int i;
    for (i = 0; i < 200 && irq_n !== 1'b0; i++) @(posedge clk);
    check({31'h0, irq_n}, 32'h0);
    if (irq_n !== 1'b0) complete_run();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and access kinds
    foreach (rows[k]) begin
      if (rows[k].wr) reg_wr(rows[k].a, rows[k].d);
      rd_chk(rows[k].a, rows[k].e);
    end
    // Line-cycle periods of three half cycles, load below threshold
    smp.active <= 24'h000020;
    reg_wr(ADDR_HALF_CYCLE_COUNT, 32'h3);
    reg_wr(ADDR_IRQ_ENABLE, 32'h4);
    reg_wr(ADDR_MODE, 32'h80);
    zc(2);
    rd_chk(ADDR_IRQ_STATUS, 32'h0);
    check({31'h0, irq_n}, 32'h1);
    zc(1);
    wait_irq();
    rd_chk(ADDR_IRQ_STATUS, 32'h4);
    rd_chk(ADDR_LINE_ACTIVE_ENERGY, 32'h0);
    reg_wr(ADDR_IRQ_STATUS, 32'h4);
    repeat (3) @(posedge clk);
    #1;
    check({31'h0, irq_n}, 32'h1);
    rd_chk(ADDR_IRQ_STATUS, 32'h0);
    // Thirty ticks of 2^22 per period give seven
    smp.active <= 24'h400000;
    smp.reactive <= 24'h400000;
    zc(6);
    rd_chk(ADDR_LINE_ACTIVE_ENERGY, 32'h7);
    rd_chk(ADDR_LINE_REACTIVE_ENERGY, 32'h7);
    // Negative power and the went-negative flag
    reg_wr(ADDR_IRQ_STATUS, 32'h1c);
    smp.active <= 24'hc00000;
    zc(6);
    rd_chk(ADDR_LINE_ACTIVE_ENERGY, 32'hfffff8);
    rd_chk(ADDR_IRQ_STATUS, 32'h14);
    // Positive-only mode drops negative power
    reg_wr(ADDR_MODE, 32'h8080);
    zc(6);
    rd_chk(ADDR_LINE_ACTIVE_ENERGY, 32'h0);
    reg_wr(ADDR_IRQ_STATUS, 32'h1c);
    smp.active <= 24'h400000;
    zc(6);
    rd_chk(ADDR_LINE_ACTIVE_ENERGY, 32'h7);
    rd_chk(ADDR_IRQ_STATUS, 32'h0c);
    // Apparent energy: 2^22 per tick, 256 ticks, three gains
    smp.i_rms <= 24'h800000;
    smp.v_rms <= 24'h800000;
    for (int g = 0; g < 3; g++) begin
      reg_wr(ADDR_APPARENT_GAIN, (g == 0) ? 32'h0 : ((g == 1) ? 32'h7ff : 32'h800));
      reg_rd(ADDR_APPARENT_ENERGY, e0);
      repeat (1024) @(posedge clk);
      reg_rd(ADDR_APPARENT_ENERGY, got);
      dlt = got[23:0] - e0[23:0];
      e0 = (g == 0) ? 32'h4 : ((g == 1) ? 32'h6 : 32'h2);
      check({31'h0, (dlt + 24'h1 >= e0[23:0]) && (dlt <= e0[23:0] + 24'h1)}, 32'h1);
    end
    // Mid-run reset with the zero-crossing pin left high
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check({31'h0, irq_n}, 32'h1);
    @(posedge clk);
    rstn <= 1'b1;
    rd_chk(ADDR_APPARENT_ENERGY, 32'h0);
    rd_chk(ADDR_MODE, 32'h0);
    rd_chk(ADDR_HALF_CYCLE_COUNT, 32'hffff);
    rd_chk(ADDR_IRQ_STATUS, 32'h0);
    complete_run();
  end
endmodule // energy_accum_tb
